//--- hw/lipm_pin_mode.sv
`timescale 1ns/1ns
// What this block does
// [R1] With the local controller off, pin zero is a level maskable request.
// [R2] With the local controller disabled, pin one is a nonmaskable interrupt.
// [R3] Both pins are asynchronous and may be sampled at any time.
// [R4] Software picks legacy or local line use by writing the controller.
// [R5] After reset the local controller is enabled, so pins are local lines.
// [R6] The serial interrupt bus runs on its own shared bus clock.
// [R7] Messages pass serially over two shared bidirectional data lines.
// [R8] Each pin goes through two synchronising flops before any decoding.
module lipm_pin_mode #(
    parameter int MSG_BITS = lipm_pkg::MSG_BITS,
    parameter int TIMEOUT_CYC = lipm_pkg::TIMEOUT_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // asynchronous interrupt pins
    input wire logic [1:0] local_irq_pins,
    // mode write from the controller register space
    input wire logic ctrl_wr,
    input wire logic ctrl_wdata,
    output logic ctrl_enabled,
    // legacy mode outputs
    output logic maskable_irq_request,
    output logic nmi_pulse,
    // local mode outputs
    output logic [1:0] local_irq_line,
    // serial interrupt bus pins
    input wire logic irq_bus_clock,
    input wire logic [1:0] irq_bus_data_in,
    output logic [1:0] irq_bus_data_out,
    output logic [1:0] irq_bus_data_oe_n,
    // message port
    input wire logic msg_tx_valid,
    input wire logic [MSG_BITS-1:0] msg_tx_data,
    output logic msg_tx_ready,
    output logic msg_rx_valid,
    output logic [MSG_BITS-1:0] msg_rx_data
);
    import lipm_pkg::*;

    logic [SYNC_STAGES-1:0] pin_sync_r [2];
    logic [1:0] pin_s;
    logic [SYNC_STAGES-1:0] bclk_sync_r;
    logic [SYNC_STAGES-1:0] bdat_sync_r [2];
    logic bclk_prev_r;
    logic nmi_prev_r;
    logic mode_r;
    logic rise_r;
    logic fall_r;
    logic [1:0] din_r;

    lipm_msg_if #(.MSG_BITS(MSG_BITS)) msg ();

    // ------------------------------------------------------------------
    // synchronisers for pins, bus clock and bus data
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_sync
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    pin_sync_r[g] <= '0;
                    bdat_sync_r[g] <= '1;
                end else if (clk_en) begin
                    pin_sync_r[g] <= {pin_sync_r[g][SYNC_STAGES-2:0],
                                      local_irq_pins[g]}; // [R3] [R8]
                    bdat_sync_r[g] <= {bdat_sync_r[g][SYNC_STAGES-2:0],
                                       irq_bus_data_in[g]}; // [R7]
                end
            end
            assign pin_s[g] = pin_sync_r[g][SYNC_STAGES-1];
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bclk_sync_r <= '0;
        end else if (clk_en) begin
            bclk_sync_r <= {bclk_sync_r[SYNC_STAGES-2:0], irq_bus_clock};
        end
    end

    // ------------------------------------------------------------------
    // bus clock edge detection
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bclk_prev_r <= 1'b0;
            rise_r <= 1'b0;
            fall_r <= 1'b0;
            din_r <= BUS_RELEASE;
        end else if (clk_en) begin
            bclk_prev_r <= bclk_sync_r[SYNC_STAGES-1];
            rise_r <= bclk_sync_r[SYNC_STAGES-1] & ~bclk_prev_r; // [R6]
            fall_r <= ~bclk_sync_r[SYNC_STAGES-1] & bclk_prev_r; // [R6]
            din_r <= {bdat_sync_r[1][SYNC_STAGES-1],
                      bdat_sync_r[0][SYNC_STAGES-1]};
        end
    end

    // ------------------------------------------------------------------
    // controller enable
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_r <= CTRL_EN_RST; // [R5]
        end else if (clk_en && ctrl_wr) begin
            mode_r <= ctrl_wdata; // [R4]
        end
    end

    // ------------------------------------------------------------------
    // mode dependent pin decoding
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_enabled <= CTRL_EN_RST;
            maskable_irq_request <= 1'b0;
            nmi_pulse <= 1'b0;
            nmi_prev_r <= 1'b0;
            local_irq_line <= 2'b00;
        end else if (clk_en) begin
            ctrl_enabled <= mode_r;
            nmi_prev_r <= pin_s[1];
            if (mode_r) begin
                local_irq_line <= pin_s; // [R5]
                maskable_irq_request <= 1'b0;
                nmi_pulse <= 1'b0;
            end else begin
                local_irq_line <= 2'b00;
                maskable_irq_request <= pin_s[0]; // [R1]
                nmi_pulse <= pin_s[1] & ~nmi_prev_r; // [R2]
            end
        end
    end

    // ------------------------------------------------------------------
    // serial message engine
    // ------------------------------------------------------------------
    assign msg.link_en = mode_r;
    assign msg.clk_rise = rise_r;
    assign msg.clk_fall = fall_r;
    assign msg.bus_din = din_r;
    assign msg.tx_valid = msg_tx_valid;
    assign msg.tx_data = msg_tx_data;

    lipm_bus_ser #(
        .MSG_BITS(MSG_BITS),
        .TIMEOUT_CYC(TIMEOUT_CYC)
    ) u_ser (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .m(msg.ser)
    );

    assign irq_bus_data_out = msg.bus_dout;
    assign irq_bus_data_oe_n = msg.bus_oe_n;
    assign msg_tx_ready = msg.tx_ready;
    assign msg_rx_valid = msg.rx_valid;
    assign msg_rx_data = msg.rx_data;
endmodule

//--- common/lipm_pkg.sv
package lipm_pkg;
    // ------------------------------------------------------------------
    // synchroniser and mode
    // ------------------------------------------------------------------
    localparam int SYNC_STAGES = 2;
    localparam logic CTRL_EN_RST = 1'b1;
    // ------------------------------------------------------------------
    // serial interrupt bus framing
    // ------------------------------------------------------------------
    localparam int MSG_BITS = 16;
    localparam logic [1:0] BUS_START = 2'b00;
    localparam logic [1:0] BUS_RELEASE = 2'b11;
    localparam logic [1:0] BUS_DRIVE_LOW = 2'b00;
    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int LINK_PERIOD_NS = 48;
    localparam int IDLE_LINK_PERIODS = 4;
    localparam int TIMEOUT_CYC =
        (IDLE_LINK_PERIODS * LINK_PERIOD_NS) / CLK_PERIOD_NS;
    // ------------------------------------------------------------------
    // serial engine states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        LIPM_S_IDLE = 3'b001,
        LIPM_S_RECV = 3'b010,
        LIPM_S_XMIT = 3'b100
    } lipm_state_t;
endpackage

//--- common/lipm_msg_if.sv
`timescale 1ns/1ns
interface lipm_msg_if #(
    parameter int MSG_BITS = 16
);
    logic link_en;
    logic clk_rise;
    logic clk_fall;
    logic [1:0] bus_din;
    logic [1:0] bus_dout;
    logic [1:0] bus_oe_n;
    logic tx_valid;
    logic [MSG_BITS-1:0] tx_data;
    logic tx_ready;
    logic rx_valid;
    logic [MSG_BITS-1:0] rx_data;

    modport top (
        output link_en, clk_rise, clk_fall, bus_din, tx_valid, tx_data,
        input bus_dout, bus_oe_n, tx_ready, rx_valid, rx_data
    );
    modport ser (
        input link_en, clk_rise, clk_fall, bus_din, tx_valid, tx_data,
        output bus_dout, bus_oe_n, tx_ready, rx_valid, rx_data
    );
endinterface

//--- hw/lipm_bus_ser.sv
`timescale 1ns/1ns
module lipm_bus_ser #(
    parameter int MSG_BITS = lipm_pkg::MSG_BITS,
    parameter int TIMEOUT_CYC = lipm_pkg::TIMEOUT_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // link side
    lipm_msg_if.ser m
);
    import lipm_pkg::*;

    localparam int PAIRS = MSG_BITS / 2;
    localparam int CW = $clog2(PAIRS + 1);
    localparam int TW = $clog2(TIMEOUT_CYC + 1);
    localparam logic [CW-1:0] LAST_PAIR = CW'(PAIRS - 1);
    localparam logic [TW-1:0] TO_LIMIT = TW'(TIMEOUT_CYC);

    lipm_state_t state_r;
    logic [CW-1:0] cnt_r;
    logic [TW-1:0] idle_cnt_r;
    logic [MSG_BITS-1:0] shreg_r;
    logic timeout;

    assign timeout = (idle_cnt_r == TO_LIMIT);

    // ------------------------------------------------------------------
    // watchdog on a stalled link clock
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            idle_cnt_r <= '0;
        end else if (clk_en) begin
            if (state_r == LIPM_S_IDLE || m.clk_rise || m.clk_fall) begin
                idle_cnt_r <= '0;
            end else if (!timeout) begin
                idle_cnt_r <= idle_cnt_r + TW'(1);
            end
        end
    end

    // ------------------------------------------------------------------
    // frame engine: sample on link rise, drive on link fall
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= LIPM_S_IDLE;
            cnt_r <= '0;
            shreg_r <= '0;
            m.bus_oe_n <= BUS_RELEASE;
            m.bus_dout <= BUS_DRIVE_LOW;
            m.tx_ready <= 1'b0;
            m.rx_valid <= 1'b0;
            m.rx_data <= '0;
        end else if (clk_en) begin
            m.tx_ready <= 1'b0;
            m.rx_valid <= 1'b0;
            unique case (state_r)
                LIPM_S_IDLE: begin
                    m.bus_oe_n <= BUS_RELEASE;
                    if (m.link_en && m.tx_valid && m.clk_fall) begin
                        // open drain: pull both lines low as start
                        m.bus_oe_n <= ~BUS_RELEASE; // [R7]
                        shreg_r <= m.tx_data;
                        cnt_r <= '0;
                        m.tx_ready <= 1'b1;
                        state_r <= LIPM_S_XMIT;
                    end else if (m.link_en && m.clk_rise
                                 && m.bus_din == BUS_START) begin
                        cnt_r <= '0;
                        state_r <= LIPM_S_RECV; // [R6]
                    end
                end
                LIPM_S_RECV: begin
                    if (timeout || !m.link_en) begin
                        state_r <= LIPM_S_IDLE;
                    end else if (m.clk_rise) begin
                        shreg_r <= {shreg_r[MSG_BITS-3:0], m.bus_din}; // [R7]
                        cnt_r <= cnt_r + CW'(1);
                        if (cnt_r == LAST_PAIR) begin
                            m.rx_valid <= 1'b1;
                            m.rx_data <= {shreg_r[MSG_BITS-3:0], m.bus_din};
                            state_r <= LIPM_S_IDLE;
                        end
                    end
                end
                LIPM_S_XMIT: begin
                    if (timeout || !m.link_en) begin
                        m.bus_oe_n <= BUS_RELEASE;
                        state_r <= LIPM_S_IDLE;
                    end else if (m.clk_fall) begin
                        if (cnt_r == CW'(PAIRS)) begin
                            m.bus_oe_n <= BUS_RELEASE;
                            state_r <= LIPM_S_IDLE;
                        end else begin
                            // a one bit releases, a zero bit pulls low
                            m.bus_oe_n <= shreg_r[MSG_BITS-1:MSG_BITS-2];
                            shreg_r <= {shreg_r[MSG_BITS-3:0], 2'b00};
                            cnt_r <= cnt_r + CW'(1); // [R6]
                        end
                    end
                end
                default: begin
                    m.bus_oe_n <= BUS_RELEASE;
                    state_r <= LIPM_S_IDLE;
                end
            endcase
        end
    end
endmodule

//--- sim/lipm_pin_mode_sva.sv
`timescale 1ns/1ns
// ----------------
// pin mode checker
// ----------------
module lipm_pin_mode_sva (
    // clock, reset, mode
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic ctrl_wr,
    input wire logic ctrl_wdata,
    input wire logic ctrl_enabled,
    // pins and outputs
    input wire logic [1:0] local_irq_pins,
    input wire logic maskable_irq_request,
    input wire logic nmi_pulse,
    input wire logic [1:0] local_irq_line,
    input wire logic [1:0] irq_bus_data_out,
    input wire logic [1:0] irq_bus_data_oe_n,
    input wire logic msg_tx_ready,
    input wire logic msg_rx_valid
);
    logic [2:0] st_r;
    logic en_d_r;
    logic ok;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    assign ok = st_r >= 3'h6;
    always_ff @(posedge clk) begin
        en_d_r <= ctrl_enabled;
    end
    always_ff @(posedge clk) begin
        if (sys_rst || !clk_en || ctrl_enabled != en_d_r)
            st_r <= 3'h0;
        else if (st_r != 3'h7)
            st_r <= st_r + 3'h1;
    end
    rst_state_a: assert property (disable iff (1'b0)
        sys_rst |=> ctrl_enabled && !nmi_pulse && local_irq_line == 2'h0
        && !maskable_irq_request && irq_bus_data_oe_n == 2'h3)
        else $error("reset state");
    line_follow_a: assert property (
        ok && ctrl_enabled |-> local_irq_line == $past(local_irq_pins, 3))
        else $error("local line");
    legacy_quiet_a: assert property (
        ok && ctrl_enabled |-> !maskable_irq_request && !nmi_pulse)
        else $error("legacy in local mode");
    mreq_level_a: assert property (
        ok && !ctrl_enabled |-> maskable_irq_request ==
        $past(local_irq_pins[0], 3) && local_irq_line == 2'h0)
        else $error("maskable level");
    nmi_edge_a: assert property (
        ok && !ctrl_enabled |-> nmi_pulse ==
        ($past(local_irq_pins[1], 3) && !$past(local_irq_pins[1], 4)))
        else $error("nmi pulse");
    mode_off_a: assert property (
        clk_en && ctrl_wr && !ctrl_wdata |-> ##[1:2] !ctrl_enabled)
        else $error("mode write");
    bus_off_a: assert property (
        ok && !ctrl_enabled |-> irq_bus_data_oe_n == 2'h3)
        else $error("bus driven when off");
    open_drain_a: assert property (
        irq_bus_data_out == 2'h0) else $error("bus driven high");
    tx_start_a: assert property (
        msg_tx_ready |-> irq_bus_data_oe_n == 2'h0 ##1 !msg_tx_ready [*8])
        else $error("frame start");
    cover property (msg_tx_ready);
    cover property (msg_rx_valid);
    cover property (nmi_pulse);
endmodule
bind lipm_pin_mode lipm_pin_mode_sva i_lipm_pin_mode_sva (.clk(clk),
    .sys_rst(sys_rst), .clk_en(clk_en), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata), .ctrl_enabled(ctrl_enabled),
    .local_irq_pins(local_irq_pins),
    .maskable_irq_request(maskable_irq_request), .nmi_pulse(nmi_pulse),
    .local_irq_line(local_irq_line), .irq_bus_data_out(irq_bus_data_out),
    .irq_bus_data_oe_n(irq_bus_data_oe_n), .msg_tx_ready(msg_tx_ready),
    .msg_rx_valid(msg_rx_valid));

//--- sim/lipm_bus_agent.sv
`timescale 1ns/1ns
// ----------------
// far bus agent
// ----------------
module lipm_bus_agent (
    // control
    input wire logic run,
    input wire logic go,
    input wire logic [15:0] sdata,
    // bus
    input wire logic [1:0] dut_oe_n,
    output logic lclk,
    output logic [1:0] lvl,
    output logic [15:0] word,
    output logic [7:0] cnt
);
    logic [1:0] pull_n = 2'h3;
    logic [3:0] rc = 4'h0;
    logic [3:0] sc = 4'h0;
    logic sent = 1'b0;
    initial begin
        lclk = 1'b0;
        word = 16'h0;
        cnt = 8'h0;
        wait (run);
        #1;
        forever begin // clock only while run is high
            wait (run);
            #24 lclk = 1'b1;
            #24 lclk = 1'b0;
        end
    end
    assign lvl = dut_oe_n & pull_n; // open drain, pulled up
    always @(negedge lclk) begin // start 00 then pairs msb first
        if (sc == 4'h0 && go && !sent) begin
            pull_n <= 2'h0;
            sc <= 4'h1;
            sent <= 1'b1;
        end else if (sc != 4'h0 && sc < 4'h9) begin
            pull_n <= sdata[17-2*sc -: 2];
            sc <= sc + 4'h1;
        end else begin
            pull_n <= 2'h3;
            sc <= 4'h0;
            if (!go) sent <= 1'b0;
        end
    end
    always @(posedge lclk) begin // receive on rising edges
        if (sc != 4'h0)
            rc <= 4'h0;
        else if (rc == 4'h0)
            rc <= lvl == 2'h0 ? 4'h1 : 4'h0;
        else begin
            word <= {word[13:0], lvl};
            rc <= rc == 4'h8 ? 4'h0 : rc + 4'h1;
            if (rc == 4'h8) cnt <= cnt + 8'h1;
        end
    end
endmodule

//--- sim/tb_top.sv
`timescale 1ns/1ns
// ----------------
// pin mode bench
// ----------------
module tb_top;
    import lipm_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic [1:0] pins = 2'h0;
    logic wr = 1'b0;
    logic wd = 1'b0;
    logic run = 1'b0;
    logic go = 1'b0;
    logic txv = 1'b0;
    logic en, mreq, nmi, lclk, rdy, rxv;
    logic [1:0] line, lvl, oe_n;
    logic [1:0] old = 2'h0;
    logic [15:0] txd = 16'h0, sd = 16'h0, rxd, word, w;
    logic [7:0] got, g0;
    int miscompares = 0;
    int cmp_count = 0;
    int seed = 71193;
    int k;
    always #(CLK_PERIOD_NS / 2) clk = ~clk;
    lipm_pin_mode i_lipm_pin_mode (.clk(clk), .sys_rst(sys_rst),
        .clk_en(clk_en), .local_irq_pins(pins), .ctrl_wr(wr),
        .ctrl_wdata(wd), .ctrl_enabled(en), .maskable_irq_request(mreq),
        .nmi_pulse(nmi), .local_irq_line(line), .irq_bus_clock(lclk),
        .irq_bus_data_in(lvl), .irq_bus_data_out(),
        .irq_bus_data_oe_n(oe_n), .msg_tx_valid(txv), .msg_tx_data(txd),
        .msg_tx_ready(rdy), .msg_rx_valid(rxv), .msg_rx_data(rxd));
    lipm_bus_agent i_lipm_bus_agent (.run(run), .go(go), .sdata(sd),
        .dut_oe_n(oe_n), .lclk(lclk), .lvl(lvl), .word(word), .cnt(got));
    function automatic logic nmi_rise(logic [1:0] o, logic [1:0] v);
        return v[1] && !o[1];
    endfunction
    function automatic logic seen(int s);
        return s == 0 ? rdy : s == 1 ? rxv : got != g0;
    endfunction
    task automatic cmp2(string n, logic [1:0] e, logic [1:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic cmp16(string n, logic [15:0] e, logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wait_on(int s);
        int i;
        for (i = 0; i < 800; i++) begin
            @(negedge clk);
            if (seen(s) === 1'b1) break;
        end
        if (i == 800) begin
            miscompares++;
            print_verdict();
        end
    endtask
    task automatic pin_run(logic le);
        logic [1:0] nv;
        int n;
        for (k = 0; k < 10; k++) begin
            nv = k < 2 ? 2'h2 : 2'($random(seed));
            @(posedge clk);
            pins <= nv;
            n = 0;
            repeat (7) begin
                @(negedge clk);
                n += int'(nmi === 1'b1);
            end
            cmp2("line", le ? nv : 2'h0, line);
            cmp2("mreq", {1'b0, !le && nv[0]}, {1'b0, mreq});
            cmp16("nmi", {15'h0, !le && nmi_rise(old, nv)}, 16'(n));
            old = nv;
        end
    endtask
    task automatic set_mode(logic v);
        @(posedge clk);
        wr <= 1'b1;
        wd <= v;
        @(posedge clk);
        wr <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        cmp2("mode", {1'b0, v}, {1'b0, en});
    endtask
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        cmp2("mode", 2'h1, {1'b0, en});
        cmp2("oe_n", 2'h3, oe_n);
        @(posedge clk);
        run <= 1'b1;
        for (k = 0; k < 3; k++) begin
            w = k == 0 ? 16'h0 : k == 1 ? 16'hb4e1 : 16'($random(seed));
            g0 = got;
            @(posedge clk);
            txv <= 1'b1;
            txd <= w;
            wait_on(0);
            @(posedge clk);
            txv <= 1'b0;
            wait_on(2);
            cmp16("tx", w, word);
            @(posedge clk);
            sd <= ~w;
            go <= 1'b1;
            wait_on(1);
            cmp16("rx", ~w, rxd);
            @(posedge clk);
            go <= 1'b0;
        end
        @(posedge clk);
        run <= 1'b0;
        $display("bus test done");
        pin_run(1'b1);
        $display("local mode test done");
        set_mode(1'b0);
        pin_run(1'b0);
        set_mode(1'b1);
        $display("legacy mode test done");
        @(posedge clk);
        clk_en <= 1'b0;
        pins <= ~old;
        repeat (7) @(negedge clk);
        cmp2("frozen", old, line);
        @(posedge clk);
        clk_en <= 1'b1;
        repeat (7) @(negedge clk);
        cmp2("line", ~old, line);
        $display("clock enable test done");
        print_verdict();
    end
endmodule
